/* File: hw/rar_pkg.sv */
// Shared constants for the rotary angle readout block.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package rar_pkg;
    // Clock and timing
    localparam int CLK_MHZ     = 125;
    localparam int SAMPLE_US   = 25;                     // Base angle refresh period
    localparam int SAMPLE_CYC  = SAMPLE_US * CLK_MHZ;    // 3125 cycles
    localparam int POWERON_US  = 300;                    // Power-on initialisation time
    localparam int POWERON_CYC = POWERON_US * CLK_MHZ;   // 37500 cycles
    // Data widths
    localparam int ANGLE_W     = 13;
    localparam int FRAME_W     = 16;
    localparam int PER_W       = 24;
    localparam int FIFO_DEPTH  = 8;
    // AXI register byte addresses
    localparam logic [3:0] ADDR_CFG  = 4'h0;
    localparam logic [3:0] ADDR_REF  = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    // Configuration fields and reset values
    localparam int CFG_EXP_LSB = 0;
    localparam int CFG_EXP_W   = 3;
    localparam int CFG_RPM_BIT = 3;
    localparam logic [31:0] CFG_RST = 32'h0000_0003;
    localparam logic [31:0] REF_RST = 32'h0000_0000;
    // Status fields
    localparam int STAT_UVL_BIT = 16;
    localparam int STAT_LOW_BIT = 17;
    localparam int STAT_RUN_BIT = 18;
    // Serial frame layout
    localparam int SPI_WR_BIT   = 15;
    localparam int SPI_ADDR_LSB = 8;
    localparam int SPI_ADDR_W   = 7;
    localparam int CTRL_RPM_BIT = 2;
    localparam int RESP_UVL_BIT = 15;
    localparam logic [6:0] SPI_REG_ANGLE = 7'h00;
    localparam logic [6:0] SPI_REG_CTRL  = 7'h01;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Power sequencing states
    typedef enum logic [1:0] {PS_INIT, PS_LOCK, PS_RUN} rar_pwr_e;
endpackage

/* File: hw/rar_readout.sv */
// Function
// - Ignore serial commands until supply is released
// - Supply-low flag travels in angle response
// - Each die holds its own speed mode
// - Read command address selects returned data
// - Low-speed period is 25 us times 2^exponent
// - Mode bit selects speed; angle always valid
// - High-speed mode samples every refresh period
// - Angle word shifted out MSB first, fixed format
// - Angle always kept as full 13-bit code
// - Read command for 0x0, answer next frame
// - Sample-to-output latency bounded by sampling, frames
// - Subtract nonvolatile reference angle from measurement
// - Output angle equals raw minus reference
// - Power-up loads defaults, speed from nonvolatile bit
// - Control bit 2 write selects low speed
//
// Holds the angle FIFO and the readout top for one die.
// Assumes raw_angle comes from converter logic on aclk; serial and supply pins are asynchronous.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ns

// Synchronous first-in first-out buffer with registered pointers
module rar_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
    logic             push, pop;

    // Pointer math; extra bit separates full from empty
    always_comb begin
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_d      = push ? wp_q + 1'b1 : wp_q;
        rp_d      = pop ? rp_q + 1'b1 : rp_q;
        in_ready  = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
        out_valid = (wp_q != rp_q);
        out_data  = mem_q[rp_q[AW-1:0]];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // Storage carries no reset; only written words are ever read
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule

module rar_readout import rar_pkg::*; #(
    parameter int POWERON_CYCLES = POWERON_CYC,
    parameter int SAMPLE_CYCLES  = SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Serial link pins
    input  wire logic               spi_sclk,
    input  wire logic               spi_cs_n,
    input  wire logic               spi_mosi,
    output logic                    spi_miso,
    output logic                    spi_miso_oe,
    // Analog front end
    input  wire logic [ANGLE_W-1:0] raw_angle,
    input  wire logic               vcc_above_release,
    input  wire logic               vcc_low_flag,
    // AXI4-Lite write channels
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [3:0]         s_axi_awaddr,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output logic [1:0]              s_axi_bresp,
    // AXI4-Lite read channels
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire logic [3:0]         s_axi_araddr,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp
);
    // Pin synchronisers; stage 0 feeds only stage 1
    logic [2:0] sclk_r, cs_r;
    logic [1:0] mosi_r, rel_r, low_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_r <= 3'h7;
            cs_r   <= 3'h7;
            mosi_r <= 2'h0;
            rel_r  <= 2'h0;
            low_r  <= 2'h0;
        end else begin
            sclk_r <= {sclk_r[1:0], spi_sclk};
            cs_r   <= {cs_r[1:0], spi_cs_n};
            mosi_r <= {mosi_r[0], spi_mosi};
            rel_r  <= {rel_r[0], vcc_above_release};
            low_r  <= {low_r[0], vcc_low_flag};
        end
    end
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    assign sclk_rise = sclk_r[1] && !sclk_r[2];
    assign sclk_fall = !sclk_r[1] && sclk_r[2];
    assign cs_fall   = !cs_r[1] && cs_r[2];
    assign cs_rise   = cs_r[1] && !cs_r[2];

    // Register file state; the nonvolatile image is emulated by cfg and ref
    logic [31:0] cfg_q, cfg_d, ref_q, ref_d;
    logic        low_speed_q, low_speed_d;

    // Power sequencing: init timer, then run while supply is released
    rar_pwr_e    pwr_q, pwr_d;
    logic [19:0] pcnt_q, pcnt_d;
    always_comb begin
        pwr_d  = pwr_q;
        pcnt_d = pcnt_q;
        case (pwr_q)
            PS_INIT: begin
                if (pcnt_q < 20'(POWERON_CYCLES - 1)) begin
                    pcnt_d = pcnt_q + 20'h1;
                end else if (rel_r[1]) begin
                    pwr_d = PS_RUN;
                end
            end
            PS_LOCK: if (rel_r[1]) pwr_d = PS_RUN;
            PS_RUN:  if (!rel_r[1]) pwr_d = PS_LOCK;
            default: pwr_d = PS_INIT;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_q  <= PS_INIT;
            pcnt_q <= 20'h0;
        end else begin
            pwr_q  <= pwr_d;
            pcnt_q <= pcnt_d;
        end
    end
    logic run;
    assign run = (pwr_q == PS_RUN);

    // Sampler: period counter and one pending sample awaiting the FIFO
    logic [PER_W-1:0]   scnt_q, scnt_d, period;
    logic               pend_q, pend_d, fifo_in_ready;
    logic [ANGLE_W-1:0] pend_ang_q, pend_ang_d;
    always_comb begin
        period = low_speed_q ? PER_W'(SAMPLE_CYCLES) << cfg_q[CFG_EXP_LSB +: CFG_EXP_W]
                             : PER_W'(SAMPLE_CYCLES);
        scnt_d     = scnt_q;
        pend_d     = pend_q;
        pend_ang_d = pend_ang_q;
        if (pend_q && fifo_in_ready) begin
            pend_d = 1'b0;
        end
        if (!run) begin
            scnt_d = '0;
        end else if (scnt_q < period - 1'b1) begin
            scnt_d = scnt_q + 1'b1;
        end else if (!pend_d) begin
            // Full FIFO stalls the counter rather than losing a sample
            scnt_d = '0;
            pend_d = 1'b1;
            // raw minus reference, modulo one turn
            pend_ang_d = raw_angle - ref_q[ANGLE_W-1:0];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scnt_q     <= '0;
            pend_q     <= 1'b0;
            pend_ang_q <= '0;
        end else begin
            scnt_q     <= scnt_d;
            pend_q     <= pend_d;
            pend_ang_q <= pend_ang_d;
        end
    end

    logic               fifo_out_valid, frame_q;
    logic [ANGLE_W-1:0] fifo_out_data;
    rar_fifo #(
        .WIDTH (ANGLE_W),
        .DEPTH (FIFO_DEPTH)
    ) rar_fifo_i (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (pend_q),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_ang_q),
        .out_valid (fifo_out_valid),
        .out_ready (!frame_q),
        .out_data  (fifo_out_data)
    );

    // latest finished sample
    // Updates only between frames so a word never changes mid-shift
    logic [ANGLE_W-1:0] ang_q, ang_d;
    always_comb begin
        ang_d = ang_q;
        if (fifo_out_valid && !frame_q) begin
            ang_d = fifo_out_data;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ang_q <= '0;
        end else begin
            ang_q <= ang_d;
        end
    end

    // Serial slave: mode 3, out on falling edge, in on rising edge
    logic [FRAME_W-1:0]    tx_q, tx_d, rx_q, rx_d, resp;
    logic [4:0]            bits_q, bits_d;
    logic [SPI_ADDR_W-1:0] addr_q, addr_d;
    logic                  miso_q, miso_d, oe_q, oe_d, frame_d;
    always_comb begin
        case (addr_q)
            SPI_REG_ANGLE: begin
                resp = '0;
                resp[RESP_UVL_BIT] = low_r[1];
                resp[ANGLE_W-1:0]  = ang_q;
            end
            SPI_REG_CTRL: begin
                resp = '0;
                resp[CTRL_RPM_BIT] = low_speed_q;
            end
            default: resp = '0;
        endcase
        tx_d        = tx_q;
        rx_d        = rx_q;
        bits_d      = bits_q;
        addr_d      = addr_q;
        miso_d      = miso_q;
        oe_d        = oe_q;
        frame_d     = frame_q;
        low_speed_d = low_speed_q;
        if (cfg_q[CFG_RPM_BIT] != cfg_d[CFG_RPM_BIT]) begin
            low_speed_d = cfg_d[CFG_RPM_BIT];
        end
        if (cs_fall && run) begin
            frame_d = 1'b1;
            oe_d    = 1'b1;
            tx_d    = resp;
            bits_d  = '0;
            miso_d  = resp[FRAME_W-1];
        end else if (cs_rise || (!run && frame_q)) begin
            frame_d = 1'b0;
            oe_d    = 1'b0;
        end else if (frame_q) begin
            if (sclk_fall) begin
                miso_d = tx_q[FRAME_W-1];
                tx_d   = {tx_q[FRAME_W-2:0], 1'b0};
            end
            if (sclk_rise && bits_q < 5'(FRAME_W)) begin
                rx_d   = {rx_q[FRAME_W-2:0], mosi_r[1]};
                bits_d = bits_q + 5'h1;
                if (bits_q == 5'(FRAME_W - 1)) begin
                    // address kept for the next frame
                    addr_d = rx_d[SPI_ADDR_LSB +: SPI_ADDR_W];
                    if (rx_d[SPI_WR_BIT] && addr_d == SPI_REG_CTRL) begin
                        low_speed_d = rx_d[CTRL_RPM_BIT];
                    end
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_q        <= '0;
            rx_q        <= '0;
            bits_q      <= '0;
            addr_q      <= SPI_REG_ANGLE;
            miso_q      <= 1'b0;
            oe_q        <= 1'b0;
            frame_q     <= 1'b0;
            low_speed_q <= CFG_RST[CFG_RPM_BIT];
        end else begin
            tx_q        <= tx_d;
            rx_q        <= rx_d;
            bits_q      <= bits_d;
            addr_q      <= addr_d;
            miso_q      <= miso_d;
            oe_q        <= oe_d;
            frame_q     <= frame_d;
            low_speed_q <= low_speed_d;
        end
    end
    assign spi_miso    = miso_q;
    assign spi_miso_oe = oe_q;

    // AXI4-Lite slave; address and data may arrive in either order
    logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, bval_q, bval_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [3:0]  awa_q, awa_d, wst_q, wst_d;
    logic [31:0] wdat_q, wdat_d, wmask;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic        arrdy_q, arrdy_d, rval_q, rval_d;
    logic [31:0] rdat_q, rdat_d;
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awa_d     = awa_q;
        wst_d     = wst_q;
        wdat_d    = wdat_q;
        bval_d    = bval_q;
        bresp_d   = bresp_q;
        cfg_d     = cfg_q;
        ref_d     = ref_q;
        wmask     = {{8{wst_q[3]}}, {8{wst_q[2]}}, {8{wst_q[1]}}, {8{wst_q[0]}}};
        if (s_axi_awvalid && awrdy_q) begin
            aw_have_d = 1'b1;
            awa_d     = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_q) begin
            w_have_d = 1'b1;
            wdat_d   = s_axi_wdata;
            wst_d    = s_axi_wstrb;
        end
        if (bval_q && s_axi_bready) begin
            bval_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bval_q) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bval_d    = 1'b1;
            bresp_d   = RESP_OKAY;
            case (awa_q)
                ADDR_CFG: cfg_d = (cfg_q & ~wmask) | (wdat_q & wmask);
                ADDR_REF: ref_d = (ref_q & ~wmask) | (wdat_q & wmask);
                ADDR_STAT: ;
                default:  bresp_d = RESP_SLVERR;
            endcase
        end
        awrdy_d = !aw_have_d;
        wrdy_d  = !w_have_d;
        // Reads answer one cycle after the address is taken
        rval_d  = rval_q;
        rdat_d  = rdat_q;
        rresp_d = rresp_q;
        if (rval_q && s_axi_rready) begin
            rval_d = 1'b0;
        end
        if (s_axi_arvalid && arrdy_q) begin
            rval_d  = 1'b1;
            rresp_d = RESP_OKAY;
            rdat_d  = '0;
            case (s_axi_araddr)
                ADDR_CFG: rdat_d = cfg_q;
                ADDR_REF: rdat_d = ref_q;
                ADDR_STAT: begin
                    rdat_d[ANGLE_W-1:0]  = ang_q;
                    rdat_d[STAT_UVL_BIT] = low_r[1];
                    rdat_d[STAT_LOW_BIT] = low_speed_q;
                    rdat_d[STAT_RUN_BIT] = run;
                end
                default: rresp_d = RESP_SLVERR;
            endcase
        end
        arrdy_d = !rval_d;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awa_q     <= '0;
            wst_q     <= '0;
            wdat_q    <= '0;
            awrdy_q   <= 1'b0;
            wrdy_q    <= 1'b0;
            bval_q    <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arrdy_q   <= 1'b0;
            rval_q    <= 1'b0;
            rdat_q    <= '0;
            rresp_q   <= RESP_OKAY;
            cfg_q     <= CFG_RST;
            ref_q     <= REF_RST;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awa_q     <= awa_d;
            wst_q     <= wst_d;
            wdat_q    <= wdat_d;
            awrdy_q   <= awrdy_d;
            wrdy_q    <= wrdy_d;
            bval_q    <= bval_d;
            bresp_q   <= bresp_d;
            arrdy_q   <= arrdy_d;
            rval_q    <= rval_d;
            rdat_q    <= rdat_d;
            rresp_q   <= rresp_d;
            cfg_q     <= cfg_d;
            ref_q     <= ref_d;
        end
    end
    assign s_axi_awready = awrdy_q;
    assign s_axi_wready  = wrdy_q;
    assign s_axi_bvalid  = bval_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arrdy_q;
    assign s_axi_rvalid  = rval_q;
    assign s_axi_rdata   = rdat_q;
    assign s_axi_rresp   = rresp_q;
endmodule

/* File: testbench/rar_readout_props.sv */
// Checker for the readout top: serial pin timing and register bus answers.
// Assumes it is bound to rar_readout and sees only that module's ports.
`timescale 1ns/1ns
module rar_readout_props import rar_pkg::*; #(
    parameter int POWERON_CYCLES = 50,
    parameter int SAMPLE_CYCLES  = 40
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Serial and supply
    input wire logic        spi_sclk,
    input wire logic        spi_cs_n,
    input wire logic        spi_miso,
    input wire logic        spi_miso_oe,
    input wire logic        vcc_above_release,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int         init_q;
    int         init_d;
    logic [3:0] addr_q;
    logic [3:0] addr_d;
    // Saturating count since reset release; address of the read under way
    always_comb begin
        init_d = (init_q < POWERON_CYCLES) ? init_q + 1 : init_q;
        addr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : addr_q;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_q <= 0;
            addr_q <= 4'h0;
        end else begin
            init_q <= init_d;
            addr_q <= addr_d;
        end
    end
    chk_init_quiet: assert property (init_q < POWERON_CYCLES |-> !spi_miso_oe)
        else $error("serial output driven during init");
    chk_lock_quiet: assert property (!vcc_above_release [*8] |-> !spi_miso_oe)
        else $error("serial output driven while supply low");
    chk_idle_quiet: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
        else $error("serial output driven outside frame");
    chk_bit_hold: assert property ((spi_miso_oe && spi_sclk && !spi_cs_n) [*4] |-> $stable(spi_miso))
        else $error("serial data moved while clock high");
    chk_oe_hold: assert property ((!spi_cs_n && spi_miso_oe) [*4] |=> spi_miso_oe)
        else $error("output enable dropped inside frame");
    chk_stat_pad: assert property (s_axi_rvalid && addr_q == ADDR_STAT |->
        s_axi_rdata[15:13] == 3'h0 && s_axi_rdata[31:19] == 13'h0)
        else $error("status word has bits beyond angle and flags");
    chk_bad_addr: assert property (s_axi_rvalid && addr_q == 4'hc |->
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    chk_ready_wake: assert property ($rose(aresetn) |=> s_axi_arready && s_axi_awready)
        else $error("bus not ready after reset");
    // Main scenarios reached
    cov_frame: cover property (spi_miso_oe && !spi_cs_n);
    cov_stat: cover property (s_axi_rvalid && addr_q == ADDR_STAT);
    cov_refuse: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

/* File: testbench/rar_readout_tb_top.sv */
// Bench for the angle readout: register bus tasks plus a serial host model.
// Assumes shortened init and sampling counts so the run stays brief.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
end
module rar_readout_tb_top import rar_pkg::*;;
    localparam int PON = 50;
    localparam int SMP = 40;
    logic        aclk, aresetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic        vcc_above_release, vcc_low_flag, ramp, oe_seen, miso_w;
    logic [12:0] raw_angle;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          mismatches, checked, cyc;
    rar_readout #(.POWERON_CYCLES(PON), .SAMPLE_CYCLES(SMP)) rar_readout_i (.*);
    rar_spi_host rar_spi_host_i (.spi_sclk, .spi_cs_n, .spi_mosi, .miso_in(miso_w));
    // Released line shows the inverse of its last bit
    assign miso_w = spi_miso_oe ? spi_miso : !spi_miso;
    always #4 aclk = ~aclk;
    // Angle ramp, enable monitor and hang limit
    always @(posedge aclk) begin
        if (ramp) raw_angle <= raw_angle + 13'h1;
        if (spi_miso_oe) oe_seen <= 1'b1;
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (PON + 10) @(posedge aclk);
    endtask
    // Bus write: both channels offered together, each released when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(ADDR_CFG, d, r);
        `CHK("cfg reset", CFG_RST, d)
        axi_rd(ADDR_REF, d, r);
        `CHK("ref reset", REF_RST, d)
        axi_rd(4'hc, d, r);
        `CHK("unmapped read", RESP_SLVERR, r)
        axi_wr(4'hc, 32'h1, r);
        `CHK("unmapped write", RESP_SLVERR, r)
        $display("t_regs done");
    endtask
    // Supply held low: a speed write sent now must be ignored
    task automatic t_lock();
        logic [15:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        oe_seen = 1'b0;
        // answer of this frame is discarded
        rar_spi_host_i.xfer({1'b1, SPI_REG_CTRL, 8'h04}, s);
        `CHK("oe while locked", 1'b0, oe_seen)
        axi_rd(ADDR_STAT, d, r);
        `CHK("run while locked", 1'b0, d[STAT_RUN_BIT])
        vcc_above_release <= 1'b1;
        repeat (10) @(posedge aclk);
        axi_rd(ADDR_STAT, d, r);
        `CHK("run after release", 1'b1, d[STAT_RUN_BIT])
        `CHK("locked write ignored", 1'b0, d[STAT_LOW_BIT])
        $display("t_lock done");
    endtask
    // Reference above raw forces the subtraction to wrap
    task automatic t_angle();
        logic [15:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        logic [12:0] e;
        e = 13'h0100 - 13'h0300;
        raw_angle <= 13'h0100;
        vcc_low_flag <= 1'b1;
        axi_wr(ADDR_REF, 32'h0000_0300, r);
        repeat (200) @(posedge aclk);
        // read command, then a second frame for the data
        rar_spi_host_i.xfer({1'b0, SPI_REG_ANGLE, 8'h00}, s);
        rar_spi_host_i.xfer({1'b0, SPI_REG_ANGLE, 8'h00}, s);
        `CHK("angle frame", {1'b1, 2'b00, e}, s)
        axi_rd(ADDR_STAT, d, r);
        `CHK("stat angle", e, d[12:0])
        `CHK("stat low flag", 1'b1, d[STAT_UVL_BIT])
        $display("t_angle done");
    endtask
    // Ramping input: successive outputs differ by exactly one period
    task automatic t_rate(input logic [31:0] cfg, input int per);
        logic [31:0] d;
        logic [1:0]  r;
        logic [12:0] a0;
        int          k;
        axi_wr(ADDR_REF, 32'h0, r);
        axi_wr(ADDR_CFG, cfg, r);
        ramp <= 1'b1;
        repeat (4 * per + 40) @(posedge aclk);
        axi_rd(ADDR_STAT, d, r);
        `CHK("mode flag", cfg[CFG_RPM_BIT], d[STAT_LOW_BIT])
        a0 = d[12:0];
        for (k = 0; k < 2; ) begin
            axi_rd(ADDR_STAT, d, r);
            if (d[12:0] !== a0) begin
                `CHK("update step", per[12:0], d[12:0] - a0)
                a0 = d[12:0];
                k++;
            end
        end
        ramp <= 1'b0;
        $display("t_rate done");
    endtask
    task automatic t_ctrl();
        logic [15:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(ADDR_CFG, CFG_RST, r);
        rar_spi_host_i.xfer({1'b1, SPI_REG_CTRL, 8'h04}, s);
        rar_spi_host_i.xfer({1'b0, SPI_REG_CTRL, 8'h00}, s);
        rar_spi_host_i.xfer({1'b0, SPI_REG_ANGLE, 8'h00}, s);
        `CHK("ctrl readback", 16'h0004, s)
        axi_rd(ADDR_STAT, d, r);
        `CHK("low speed by serial", 1'b1, d[STAT_LOW_BIT])
        $display("t_ctrl done");
    endtask
    // Second reset: defaults return, speed from the default bit
    task automatic t_rst();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(ADDR_REF, 32'h0000_0055, r);
        do_reset();
        axi_rd(ADDR_REF, d, r);
        `CHK("ref after reset", REF_RST, d)
        axi_rd(ADDR_STAT, d, r);
        `CHK("speed after reset", CFG_RST[CFG_RPM_BIT], d[STAT_LOW_BIT])
        $display("t_rst done");
    endtask
    initial begin
        {aclk, aresetn, ramp, oe_seen, vcc_above_release, vcc_low_flag} = 6'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hf;
        raw_angle = 13'h0;
        {mismatches, checked, cyc} = '0;
        do_reset();
        t_regs();
        t_lock();
        t_angle();
        t_rate(32'h0000_0003, SMP);
        t_rate(32'h0000_0009, SMP << 1);
        t_rate(32'h0000_0008, SMP);
        t_ctrl();
        t_rst();
        finish_test();
    end
endmodule
bind rar_readout rar_readout_props #(.POWERON_CYCLES(POWERON_CYCLES),
    .SAMPLE_CYCLES(SAMPLE_CYCLES)) rar_readout_props_i (.*);

/* File: testbench/rar_spi_host.sv */
// Host model: serial master, mode 3, 16-bit frames, clock still between frames.
// Assumes the device updates its data within the low half of each clock period.
`timescale 1ns/1ns
module rar_spi_host #(
    parameter int HALF_NS = 40
) (
    // Serial link pins
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic miso_in
);
    // Idle: clock high, not selected
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // One frame; data changes on falling clock, sampled on rising clock
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        spi_cs_n = 1'b0;
        #100;
        for (int i = 15; i >= 0; i--) begin
            spi_sclk = 1'b0;
            spi_mosi = cmd[i];
            #HALF_NS;
            spi_sclk = 1'b1;
            rsp[i] = miso_in;
            #HALF_NS;
        end
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;  // Released line shows no stale value
        #400;
    endtask
endmodule
